// [verilog/spics_top.sv]
// spics_top: serial port control/status register, flags, select wiring and byte shifter.
// assumes an 8-bit sfr bus with byte and bit writes; link pins are asynchronous to clk.
`timescale 1ns/1ps

module spics_top #(
  parameter int CLK_DIV = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic master_enable_bit,
  input wire logic port_irq_enable,
  output logic irq_req,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_in,
  output logic slave_select_out,
  output logic slave_select_oe
);
  typedef enum {SPICS_IDLE, SPICS_LOW, SPICS_HIGH} spics_state_t;

  spics_sync_if sck_if();
  spics_sync_if mosi_if();
  spics_sync_if miso_if();
  spics_sync_if ss_if();

  spics_sync u_sync_sck (.clk(clk), .sys_rst(sys_rst), .port_if(sck_if.sync));
  spics_sync u_sync_mosi (.clk(clk), .sys_rst(sys_rst), .port_if(mosi_if.sync));
  spics_sync u_sync_miso (.clk(clk), .sys_rst(sys_rst), .port_if(miso_if.sync));
  spics_sync u_sync_ss (.clk(clk), .sys_rst(sys_rst), .port_if(ss_if.sync));

  assign sck_if.raw = sck_in;
  assign mosi_if.raw = mosi_in;
  assign miso_if.raw = miso_in;
  assign ss_if.raw = slave_select_in;

  logic done_reg;
  logic write_collision_flag_reg;
  logic mode_fault_flag_reg;
  logic ovrn_reg;
  logic [1:0] smd_reg;
  logic txe_reg;
  logic en_reg;
  logic [7:0] txbuf_reg;
  logic [7:0] rxbuf_reg;
  logic rx_full_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] div_reg;
  logic sck_prev_reg;
  logic ss_prev_reg;
  spics_state_t state_reg;

  logic ctrl_wr;
  logic ctrl_bwr;
  logic data_wr;
  logic data_rd;
  logic [7:0] ctrl_wval;
  logic ctrl_view;
  logic is_master;
  logic slave_sel;
  logic sck_rise;
  logic sck_fall;
  logic load_shift;
  logic start_xfer;
  logic byte_done;
  logic div_tick;

  assign ctrl_wr = sfr_wr && (sfr_addr == spics_pkg::CTRL_ADDR);
  assign ctrl_bwr = sfr_bit_wr && (sfr_addr == spics_pkg::CTRL_ADDR);
  assign data_wr = sfr_wr && (sfr_addr == spics_pkg::DATA_ADDR);
  assign data_rd = sfr_rd && (sfr_addr == spics_pkg::DATA_ADDR);

  // merged write value: byte write or single-bit write over current contents
  always_comb begin
    ctrl_wval = {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovrn_reg, smd_reg, txe_reg, en_reg};
    if (ctrl_wr) begin
      ctrl_wval = sfr_wdata;
    end else if (ctrl_bwr) begin
      ctrl_wval[sfr_bit_sel] = sfr_wdata[0];
    end
  end
  assign ctrl_view = ctrl_wr || ctrl_bwr;

  assign is_master = en_reg && master_enable_bit;
  // slave selected: 3-wire always, 4-wire only while select low
  assign slave_sel = en_reg && !master_enable_bit &&
                     ((smd_reg == spics_pkg::SMD_3WIRE) || !ss_if.safe);
  assign sck_rise = ss_if.safe == ss_prev_reg && sck_if.safe && !sck_prev_reg;
  assign sck_fall = !sck_if.safe && sck_prev_reg;
  assign div_tick = div_reg == 8'(CLK_DIV - 1);
  // a master starts only with a byte waiting; a selected slave starts regardless
  assign start_xfer = (state_reg == SPICS_IDLE) && ((is_master && !txe_reg) || slave_sel);
  assign load_shift = start_xfer && !txe_reg;
  assign byte_done = (bit_cnt_reg == 4'(spics_pkg::DATA_BITS)) && (state_reg != SPICS_IDLE);

  // edge history of the synchronised link lines
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_if.safe;
      ss_prev_reg <= ss_if.safe;
    end
  end

  // master clock divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 8'h00;
    end else if (div_tick || state_reg == SPICS_IDLE) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // transfer sequencer and shift register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SPICS_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (!en_reg) begin
      state_reg <= SPICS_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        SPICS_IDLE: begin
          if (start_xfer) begin
            shift_reg <= txbuf_reg;
            bit_cnt_reg <= 4'h0;
            state_reg <= SPICS_LOW;
          end
        end
        SPICS_LOW: begin
          if (byte_done) begin
            state_reg <= SPICS_IDLE;
          end else if (is_master && div_tick) begin
            state_reg <= SPICS_HIGH;
          end else if (!is_master && slave_sel && sck_rise) begin
            shift_reg <= {shift_reg[6:0], mosi_if.safe};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (!is_master && !slave_sel) begin
            state_reg <= SPICS_IDLE;
          end
        end
        SPICS_HIGH: begin
          if (div_tick) begin
            shift_reg <= {shift_reg[6:0], miso_if.safe};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            state_reg <= SPICS_LOW;
          end
        end
        default: begin
          state_reg <= SPICS_IDLE;
        end
      endcase
    end
  end

  // receive buffer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxbuf_reg <= 8'h00;
      rx_full_reg <= 1'b0;
    end else if (byte_done) begin
      rxbuf_reg <= shift_reg;
      rx_full_reg <= 1'b1;
    end else if (data_rd) begin
      rx_full_reg <= 1'b0;
    end
  end

  // transmit buffer and empty flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txbuf_reg <= 8'h00;
      txe_reg <= spics_pkg::CTRL_RESET[spics_pkg::BIT_TXE];
    end else if (data_wr && txe_reg) begin
      txbuf_reg <= sfr_wdata;
      txe_reg <= 1'b0;
    end else if (load_shift) begin
      txe_reg <= 1'b1;
    end
  end

  // control fields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      smd_reg <= spics_pkg::CTRL_RESET[spics_pkg::BIT_SMD_HI:spics_pkg::BIT_SMD_LO];
      en_reg <= spics_pkg::CTRL_RESET[spics_pkg::BIT_EN];
    end else if (ctrl_view) begin
      smd_reg <= ctrl_wval[spics_pkg::BIT_SMD_HI:spics_pkg::BIT_SMD_LO];
      en_reg <= ctrl_wval[spics_pkg::BIT_EN];
    end
  end

  // sticky flags: hardware set wins over software clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      ovrn_reg <= 1'b0;
    end else begin
      if (byte_done) begin
        done_reg <= 1'b1;
      end else if (ctrl_view) begin
        done_reg <= ctrl_wval[spics_pkg::BIT_DONE];
      end
      if (data_wr && !txe_reg) begin
        write_collision_flag_reg <= 1'b1;
      end else if (ctrl_view) begin
        write_collision_flag_reg <= ctrl_wval[spics_pkg::BIT_WRITE_COLLISION_FLAG];
      end
      if (is_master && smd_reg == spics_pkg::SMD_4WIRE_SLAVE && !ss_if.safe) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (ctrl_view) begin
        mode_fault_flag_reg <= ctrl_wval[spics_pkg::BIT_MODE_FAULT_FLAG];
      end
      if (byte_done && !is_master && rx_full_reg && !data_rd) begin
        ovrn_reg <= 1'b1;
      end else if (ctrl_view) begin
        ovrn_reg <= ctrl_wval[spics_pkg::BIT_OVRN];
      end
    end
  end

  // registered outputs: read data, interrupt, pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      irq_req <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      slave_select_out <= 1'b1;
      slave_select_oe <= 1'b0;
    end else begin
      if (sfr_addr == spics_pkg::CTRL_ADDR) begin
        sfr_rdata <= {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovrn_reg, smd_reg, txe_reg, en_reg};
      end else if (sfr_addr == spics_pkg::DATA_ADDR) begin
        sfr_rdata <= rxbuf_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
      irq_req <= port_irq_enable && (done_reg || write_collision_flag_reg || mode_fault_flag_reg || ovrn_reg);
      sck_out <= state_reg == SPICS_HIGH;
      sck_oe <= is_master;
      mosi_out <= shift_reg[7];
      mosi_oe <= is_master;
      miso_out <= shift_reg[7];
      miso_oe <= slave_sel;
      slave_select_out <= smd_reg[0];
      slave_select_oe <= en_reg && smd_reg[1];
    end
  end
endmodule : spics_top

// [include/spics_pkg.sv]
// spics_pkg: constants shared by the serial port control/status design files.
// assumes an 8-bit special-function-register bus with bit addressing.
package spics_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hF8;
  localparam logic [7:0] DATA_ADDR = 8'hA3;
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_MODE_FAULT_FLAG = 5;
  localparam int BIT_OVRN = 4;
  localparam int BIT_SMD_HI = 3;
  localparam int BIT_SMD_LO = 2;
  localparam int BIT_TXE = 1;
  localparam int BIT_EN = 0;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [1:0] SMD_3WIRE = 2'h0;
  localparam logic [1:0] SMD_4WIRE_SLAVE = 2'h1;
  localparam int SYNC_STAGES = 2;
  localparam int DATA_BITS = 8;
endpackage : spics_pkg

// [include/spics_sync_if.sv]
// spics_sync_if: carries one raw pin level into the synchroniser and its safe copy back.
// assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface spics_sync_if;
  logic raw;
  logic safe;
  modport sync (input raw, output safe);
  modport user (output raw, input safe);
endinterface : spics_sync_if

// [verilog/spics_sync.sv]
// spics_sync: two-flop synchroniser for one pin level.
// assumes clk is the system clock; raw may change at any time.
`timescale 1ns/1ps
module spics_sync (
  input wire logic clk,
  input wire logic sys_rst,
  spics_sync_if.sync port_if
);
  logic [spics_pkg::SYNC_STAGES-1:0] stage_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[spics_pkg::SYNC_STAGES-2:0], port_if.raw};
    end
  end

  assign port_if.safe = stage_reg[spics_pkg::SYNC_STAGES-1];
endmodule : spics_sync

// [dv/spics_monitor.sv]
// spics_monitor: port assertions for the serial port control/status block.
// assumes binding into spics_top, one clock domain.
`timescale 1ns/1ps
module spics_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic port_irq_enable,
  input wire logic irq_req,
  input wire logic slave_select_out,
  input wire logic slave_select_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_ctrl_wr;
    sfr_wr && sfr_addr == spics_pkg::CTRL_ADDR;
  endsequence
  sequence s_bit_clear(logic [2:0] s);
    sfr_bit_wr && sfr_bit_sel == s && !sfr_wdata[0] && sfr_addr == spics_pkg::CTRL_ADDR
      ##1 sfr_addr == spics_pkg::CTRL_ADDR;
  endsequence
  property p_clear(logic [2:0] s);
    s_bit_clear(s) |=> !sfr_rdata[s];
  endproperty
  a_irq_masked_off: assert property (!port_irq_enable |=> !irq_req) else $error("irq while masked");
  a_irq_flag_mirror: assert property ($past(sfr_addr) == spics_pkg::CTRL_ADDR && $past(port_irq_enable)
    |-> irq_req == (|sfr_rdata[7:4])) else $error("irq differs from flags");
  a_unmapped_zero: assert property (sfr_addr != spics_pkg::CTRL_ADDR && sfr_addr != spics_pkg::DATA_ADDR
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_single_master: assert property (s_ctrl_wr ##0 sfr_wdata[3] && sfr_wdata[0]
    |-> ##2 slave_select_oe && slave_select_out == $past(sfr_wdata[2], 2)) else $error("select not driven");
  a_select_released: assert property (s_ctrl_wr ##0 !(sfr_wdata[3] && sfr_wdata[0])
    |-> ##2 !slave_select_oe) else $error("select driven");
  a_done_clear: assert property (p_clear(3'h7)) else $error("done flag not cleared");
  a_write_collision_flag_clear: assert property (p_clear(3'h6)) else $error("collision flag not cleared");
  a_fault_clear: assert property (p_clear(3'h5)) else $error("fault flag not cleared");
  a_ovrn_clear: assert property (p_clear(3'h4)) else $error("overrun flag not cleared");
endmodule : spics_monitor
bind spics_top spics_monitor i_spics_monitor (
  .clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel, .sfr_wdata,
  .sfr_rdata, .port_irq_enable, .irq_req, .slave_select_out, .slave_select_oe
);

// [dv/spics_peer.sv]
// spics_peer: far-side serial device, master or slave, and pin resolution.
// assumes the bench calls send_byte; link clock runs only within frames.
`timescale 1ns/1ps
module spics_peer (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic slave_select_out,
  input wire logic slave_select_oe,
  output logic sck_in,
  output logic mosi_in,
  output logic miso_in,
  output logic slave_select_in
);
  logic sck_d = 1'b0;
  logic mosi_d = 1'b0;
  logic ss_d = 1'b1;
  logic [7:0] tx_sh = 8'h00;
  logic [7:0] rx_sh = 8'h00;
  logic [7:0] miso_sh = 8'h00;
  assign sck_in = sck_oe ? sck_out : sck_d;
  assign mosi_in = mosi_oe ? mosi_out : mosi_d;
  assign miso_in = miso_oe ? miso_out : tx_sh[7];
  assign slave_select_in = slave_select_oe ? slave_select_out : ss_d;
  // slave role: sample on rising, shift reply out on falling, msb first
  always @(posedge sck_in) begin
    if (sck_oe) rx_sh <= {rx_sh[6:0], mosi_in};
  end
  always @(negedge sck_in) begin
    if (sck_oe) tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
  end
  // master role: capture the slave reply on our own rising edges
  always @(posedge sck_d) begin
    miso_sh <= {miso_sh[6:0], miso_in};
  end
  // master role: 125 ns link clock, data set before each rising edge
  task automatic send_byte(input logic [7:0] b);
    ss_d = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_d = b[i];
      #62.5 sck_d = 1'b1;
      #62.5 sck_d = 1'b0;
    end
    mosi_d = ~b[0];
    #100 ss_d = 1'b1;
  endtask : send_byte
endmodule : spics_peer

// [dv/spics_tb_top.sv]
// spics_tb_top: directed bench for the serial port control/status block.
// assumes spics_top with the peer model on its link pins; 100 MHz clock.
`timescale 1ns/1ps
module spics_tb_top;
  logic clk, sys_rst, sfr_wr, sfr_bit_wr, sfr_rd, master_enable_bit, port_irq_enable, irq_req;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [2:0] sfr_bit_sel;
  logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic slave_select_in, slave_select_out, slave_select_oe;
  int n_errors = 0;
  int n_checks = 0;
  spics_top i_spics_top (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel, .sfr_wdata, .sfr_rd,
    .sfr_rdata, .master_enable_bit, .port_irq_enable, .irq_req, .sck_in, .sck_out, .sck_oe, .mosi_in,
    .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .slave_select_in, .slave_select_out, .slave_select_oe);
  spics_peer i_spics_peer (.sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_out, .miso_oe, .slave_select_out,
    .slave_select_oe, .sck_in, .mosi_in, .miso_in, .slave_select_in);
  task automatic print_verdict;
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic bc(input logic [2:0] s);
    @(negedge clk);
    sfr_addr = spics_pkg::CTRL_ADDR;
    sfr_bit_sel = s;
    sfr_wdata = 8'h00;
    sfr_bit_wr = 1'b1;
    @(negedge clk);
    sfr_bit_wr = 1'b0;
  endtask : bc
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic t_reset;
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h06);
    rd(8'h55);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_off;
    wr(spics_pkg::CTRL_ADDR, 8'h08);
    i_spics_peer.send_byte(8'hFF);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h0A);
    chk({4'h0, sck_oe, mosi_oe, miso_oe, slave_select_oe}, 8'h00);
  endtask : t_off
  task automatic t_slave;
    wr(spics_pkg::CTRL_ADDR, 8'h05);
    wr(spics_pkg::DATA_ADDR, 8'h69);
    i_spics_peer.send_byte(8'h3C);
    chk(i_spics_peer.miso_sh, 8'h69);
    rd(spics_pkg::DATA_ADDR);
    chk(d, 8'h3C);
    i_spics_peer.send_byte(8'h96);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h87);
    i_spics_peer.send_byte(8'h5A);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h97);
    bc(3'h7);
    bc(3'h4);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h07);
  endtask : t_slave
  task automatic t_fault;
    master_enable_bit = 1'b1;
    wr(spics_pkg::CTRL_ADDR, 8'h01);
    i_spics_peer.ss_d = 1'b0;
    repeat (4) @(negedge clk);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h03);
    wr(spics_pkg::CTRL_ADDR, 8'h05);
    repeat (4) @(negedge clk);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h27);
    i_spics_peer.ss_d = 1'b1;
    repeat (4) @(negedge clk);
    bc(3'h5);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h07);
  endtask : t_fault
  task automatic t_master;
    port_irq_enable = 1'b1;
    i_spics_peer.tx_sh = 8'hC3;
    wr(spics_pkg::CTRL_ADDR, 8'h09);
    @(negedge clk);
    chk({6'h00, slave_select_oe, slave_select_out}, 8'h02);
    sfr_addr = spics_pkg::DATA_ADDR;
    sfr_wdata = 8'hA5;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wdata = 8'h5A;
    @(negedge clk);
    sfr_wr = 1'b0;
    for (int i = 0; i < 300 && d[7] !== 1'b1; i++) rd(spics_pkg::CTRL_ADDR);
    if (d[7] !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    chk(d & 8'hC2, 8'hC2);
    repeat (100) @(negedge clk);
    chk(i_spics_peer.rx_sh, 8'hA5);
    rd(spics_pkg::DATA_ADDR);
    chk(d, 8'hC3);
    chk({7'h00, irq_req}, 8'h01);
    bc(3'h7);
    bc(3'h6);
    rd(spics_pkg::CTRL_ADDR);
    chk(d, 8'h0B);
    chk({7'h00, irq_req}, 8'h00);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h06);
    wr(spics_pkg::CTRL_ADDR, 8'h0D);
    @(negedge clk);
    chk({6'h00, slave_select_oe, slave_select_out}, 8'h03);
  endtask : t_master
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {sys_rst, sfr_wr, sfr_bit_wr, sfr_rd, master_enable_bit, port_irq_enable} = 6'h20;
    {sfr_addr, sfr_wdata, sfr_bit_sel, d} = 27'h0000000;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_off();
    t_slave();
    t_fault();
    t_master();
    print_verdict();
  end
endmodule : spics_tb_top
